// File: pkg/dbg_auth_pkg.sv
// Contract
// [R1] give security-core challenge, await response before access
// [R2] 128-bit challenge and response, bit 127 first
// [R3] target code 0 main core, 1 security core
// [R4] good response connects with success, bad reports error
// [R5] halt security core during debugger flash access
// [R6] halt security core during option byte access
// [R7] halt security core while break instruction patched
// [R8] debugger reset resets every core
// [R9] ignore security-core reset while main core in break
// [R10] peripheral-break enabled stops peripherals during break
// [R11] users disable peripheral break if security core needs them
// [R12] refuse execution and memory access until authenticated
package dbg_auth_pkg;
	// ----------------------------------------
	// challenge and response framing
	// ----------------------------------------
	localparam int CR_WIDTH = 128;
	localparam int CR_CNT_W = $clog2(CR_WIDTH);
	localparam int NUM_TARGETS = 2;
	localparam logic TGT_MAIN = 1'b0;
	localparam logic TGT_SEC = 1'b1;
	localparam logic [CR_WIDTH-1:0] CR_ZERO = {CR_WIDTH{1'b0}};

	// ----------------------------------------
	// authentication sequencer, gray along the pass path
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHAL_REQ = 3'h1,
		ST_CHAL_OUT = 3'h3,
		ST_RESP_IN = 3'h2,
		ST_VERIFY = 3'h6,
		ST_DONE = 3'h7
	} auth_state_t;
endpackage : dbg_auth_pkg

// File: verilog/cr_shift.sv
`timescale 1ns/1ps
module cr_shift import dbg_auth_pkg::*; #(
	parameter int W = CR_WIDTH,
	parameter int CW = CR_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// parallel side
	input wire logic load,
	input wire logic [W-1:0] load_data,
	output logic [W-1:0] par_out,
	// serial side, msb first
	input wire logic shift,
	input wire logic ser_in,
	output logic ser_out,
	output logic last
);
	logic [W-1:0] data_reg;
	logic [CW-1:0] cnt_reg;
	localparam logic [CW-1:0] CNT_LAST = CW'(W - 1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_reg <= '0;
		end else if (load) begin
			data_reg <= load_data;
		end else if (shift) begin
			data_reg <= {data_reg[W-2:0], ser_in}; // R2
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || load) begin
			cnt_reg <= '0;
		end else if (shift) begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

	assign par_out = data_reg;
	assign ser_out = data_reg[W-1];
	assign last = shift && (cnt_reg == CNT_LAST);
endmodule : cr_shift

// File: verilog/dbg_auth_ctrl.sv
`timescale 1ns/1ps
module dbg_auth_ctrl import dbg_auth_pkg::*; (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// debug probe connection
	input wire logic DBG_CONNECT_PIN,
	input wire logic DBG_AUTH_REQUIRED,
	input wire logic DBG_TARGET,
	output logic DBG_CONNECTED,
	output logic AUTH_OK,
	output logic AUTH_ERR,
	output logic [NUM_TARGETS-1:0] AUTH_GRANTED,
	// challenge stream to the probe
	input wire logic CHAL_RDY,
	output logic CHAL_STB,
	output logic CHAL_BIT,
	// response stream from the probe
	input wire logic RESP_STB,
	input wire logic RESP_BIT,
	// security core authentication service
	output logic SEC_CHAL_REQ,
	output logic SEC_CHAL_TARGET,
	input wire logic SEC_CHAL_VALID,
	input wire logic [CR_WIDTH-1:0] SEC_CHAL_DATA,
	output logic SEC_RESP_VALID,
	output logic [CR_WIDTH-1:0] SEC_RESP_DATA,
	input wire logic SEC_VERDICT_VALID,
	input wire logic SEC_VERDICT_PASS,
	// debugger access requests
	input wire logic DBG_EXEC_REQ,
	input wire logic DBG_MEM_REQ,
	input wire logic DBG_FLASH_ACC,
	input wire logic DBG_OPTB_ACC,
	input wire logic DBG_SWBRK_PATCH,
	output logic EXEC_GRANT,
	output logic MEM_GRANT,
	output logic ACC_DENIED,
	output logic SEC_HALT,
	// resets and break
	input wire logic DBG_RESET_REQ,
	input wire logic SEC_RESET_REQ,
	input wire logic MAIN_IN_BREAK,
	input wire logic PERI_BRK_EN,
	output logic ALL_CORE_RST,
	output logic PERI_STOP
);
	// ----------------------------------------
	// connect pin synchroniser
	// ----------------------------------------
	logic conn_meta_reg, conn_sync_reg, conn_prev_reg;
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			conn_meta_reg <= 1'b0;
			conn_sync_reg <= 1'b0;
			conn_prev_reg <= 1'b0;
		end else begin
			conn_meta_reg <= DBG_CONNECT_PIN;
			conn_sync_reg <= conn_meta_reg;
			conn_prev_reg <= conn_sync_reg;
		end
	end
	logic conn_rise;
	assign conn_rise = conn_sync_reg && !conn_prev_reg;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	auth_state_t state_reg, state_next;
	logic tgt_reg;
	logic chal_last, resp_last, chal_shift, resp_shift;
	logic [CR_WIDTH-1:0] chal_par, resp_par;
	logic verdict_pass, verdict_fail;

	assign chal_shift = (state_reg == ST_CHAL_OUT) && CHAL_RDY;
	assign resp_shift = (state_reg == ST_RESP_IN) && RESP_STB;
	assign verdict_pass = (state_reg == ST_VERIFY) && SEC_VERDICT_VALID && SEC_VERDICT_PASS;
	assign verdict_fail = (state_reg == ST_VERIFY) && SEC_VERDICT_VALID && !SEC_VERDICT_PASS;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (conn_rise) begin
					state_next = DBG_AUTH_REQUIRED ? ST_CHAL_REQ : ST_DONE;
				end
			end
			ST_CHAL_REQ: begin
				if (SEC_CHAL_VALID) begin
					state_next = ST_CHAL_OUT; // R1
				end
			end
			ST_CHAL_OUT: begin
				if (chal_last) begin
					state_next = ST_RESP_IN;
				end
			end
			ST_RESP_IN: begin
				if (resp_last) begin
					state_next = ST_VERIFY; // R1
				end
			end
			ST_VERIFY: begin
				if (verdict_pass) begin
					state_next = ST_DONE; // R4
				end else if (verdict_fail) begin
					state_next = ST_IDLE; // R4
				end
			end
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		// a dropped probe abandons any authentication in flight
		if (!conn_sync_reg) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			tgt_reg <= TGT_MAIN;
		end else if (state_reg == ST_IDLE && conn_rise) begin
			tgt_reg <= DBG_TARGET; // R3
		end
	end

	// a direct connect grants on the edge that loads tgt_reg, so use the live target there
	logic tgt_now;
	assign tgt_now = (state_reg == ST_IDLE) ? DBG_TARGET : tgt_reg; // R3

	// ----------------------------------------
	// challenge and response shifters
	// ----------------------------------------
	cr_shift #(.W(CR_WIDTH), .CW(CR_CNT_W)) u_chal (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.load((state_reg == ST_CHAL_REQ) && SEC_CHAL_VALID),
		.load_data(SEC_CHAL_DATA),
		.par_out(chal_par),
		.shift(chal_shift),
		.ser_in(1'b0),
		.ser_out(),
		.last(chal_last)
	);
	cr_shift #(.W(CR_WIDTH), .CW(CR_CNT_W)) u_resp (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.load((state_reg == ST_CHAL_REQ) && SEC_CHAL_VALID),
		.load_data(CR_ZERO),
		.par_out(resp_par),
		.shift(resp_shift),
		.ser_in(RESP_BIT),
		.ser_out(),
		.last(resp_last)
	);
	assign SEC_RESP_DATA = resp_par;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			CHAL_STB <= 1'b0;
			CHAL_BIT <= 1'b0;
			SEC_RESP_VALID <= 1'b0;
			SEC_CHAL_REQ <= 1'b0;
			SEC_CHAL_TARGET <= TGT_MAIN;
		end else begin
			CHAL_STB <= chal_shift;
			CHAL_BIT <= chal_shift ? chal_par[CR_WIDTH-1] : 1'b0; // R2
			SEC_RESP_VALID <= resp_last; // R1
			SEC_CHAL_REQ <= (state_reg == ST_IDLE) && conn_rise && DBG_AUTH_REQUIRED; // R1
			if (state_reg == ST_IDLE && conn_rise) begin
				SEC_CHAL_TARGET <= DBG_TARGET; // R3
			end
		end
	end

	// ----------------------------------------
	// outcome and per-target grants
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			AUTH_OK <= 1'b0;
			AUTH_ERR <= 1'b0;
			DBG_CONNECTED <= 1'b0;
		end else begin
			AUTH_OK <= verdict_pass; // R4
			AUTH_ERR <= verdict_fail && conn_sync_reg; // R4
			DBG_CONNECTED <= (state_next == ST_DONE); // R4
		end
	end

	// grants are per target so one pass never opens the other core
	genvar g;
	generate
		for (g = 0; g < NUM_TARGETS; g++) begin : g_tgt
			always_ff @(posedge SYS_CLK) begin
				if (!RST_N) begin
					AUTH_GRANTED[g] <= 1'b0;
				end else if (!conn_sync_reg) begin
					AUTH_GRANTED[g] <= 1'b0;
				end else if (state_reg != ST_DONE && state_next == ST_DONE &&
					tgt_now == 1'(g)) begin
					AUTH_GRANTED[g] <= 1'b1; // R3
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// access gating and security core halt
	// ----------------------------------------
	logic main_ok;
	assign main_ok = AUTH_GRANTED[TGT_MAIN];

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			EXEC_GRANT <= 1'b0;
			MEM_GRANT <= 1'b0;
			ACC_DENIED <= 1'b0;
		end else begin
			EXEC_GRANT <= DBG_EXEC_REQ && main_ok; // R12
			MEM_GRANT <= (DBG_MEM_REQ || DBG_FLASH_ACC || DBG_OPTB_ACC) && main_ok; // R12
			ACC_DENIED <= (DBG_EXEC_REQ || DBG_MEM_REQ || DBG_FLASH_ACC || DBG_OPTB_ACC ||
				DBG_SWBRK_PATCH) && !main_ok; // R12
		end
	end

	// halt also covers the patch step so the flash is never shared mid-rewrite
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SEC_HALT <= 1'b0;
		end else begin
			SEC_HALT <= main_ok && (DBG_FLASH_ACC || DBG_OPTB_ACC || DBG_SWBRK_PATCH); // R5 R6 R7
		end
	end

	// ----------------------------------------
	// resets and peripheral break
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ALL_CORE_RST <= 1'b0;
		end else begin
			ALL_CORE_RST <= DBG_RESET_REQ || (SEC_RESET_REQ && !MAIN_IN_BREAK); // R8 R9
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PERI_STOP <= 1'b0;
		end else begin
			PERI_STOP <= PERI_BRK_EN && MAIN_IN_BREAK; // R10
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	logic [CR_WIDTH-1:0] chal_ref_reg;
	logic [CR_CNT_W-1:0] chal_idx_reg;
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			chal_ref_reg <= '0;
			chal_idx_reg <= '0;
		end else if (state_reg == ST_CHAL_REQ && SEC_CHAL_VALID) begin
			chal_ref_reg <= SEC_CHAL_DATA;
			chal_idx_reg <= '0;
		end else if (CHAL_STB) begin
			chal_idx_reg <= chal_idx_reg + CR_CNT_W'(1);
		end
	end

	sequence s_pass;
		verdict_pass && conn_sync_reg;
	endsequence
	sequence s_fail;
		verdict_fail && conn_sync_reg;
	endsequence
	sequence s_ok_pulse;
		AUTH_OK ##1 !AUTH_OK;
	endsequence

	AST_NO_GRANT_BEFORE_VERDICT: assert property ( // R1
		(state_reg == ST_RESP_IN || state_reg == ST_VERIFY) |-> !DBG_CONNECTED)
		else $error("connected before response verified");
	AST_CHAL_MSB_FIRST: assert property ( // R2
		CHAL_STB |-> CHAL_BIT == chal_ref_reg[CR_CNT_W'(CR_WIDTH - 1) - chal_idx_reg])
		else $error("challenge bit out of order");
	AST_TARGET_GRANT: assert property ( // R3
		s_pass ##0 (tgt_reg == TGT_SEC) |=> AUTH_GRANTED[TGT_SEC] && DBG_CONNECTED)
		else $error("security core target not granted");
	AST_NOAUTH_GRANT: assert property ( // R3
		(state_reg == ST_IDLE) && conn_rise && !DBG_AUTH_REQUIRED |=>
		AUTH_GRANTED[$past(DBG_TARGET)] && DBG_CONNECTED)
		else $error("direct connect granted wrong target");
	AST_PASS_REPORT: assert property ( // R4
		s_pass |=> s_ok_pulse and DBG_CONNECTED[*2])
		else $error("pass not reported");
	AST_FAIL_REPORT: assert property ( // R4
		s_fail |=> AUTH_ERR && !DBG_CONNECTED ##1 !AUTH_ERR)
		else $error("failure not reported");
	AST_FLASH_HALT: assert property ( // R5
		(DBG_FLASH_ACC || DBG_OPTB_ACC) && main_ok |=> SEC_HALT && MEM_GRANT)
		else $error("security core not halted for flash access");
	AST_PATCH_HALT: assert property ( // R7
		DBG_SWBRK_PATCH && main_ok |=> SEC_HALT)
		else $error("security core not halted for break patch");
	AST_DBG_RESET: assert property ( // R8
		DBG_RESET_REQ |=> ALL_CORE_RST)
		else $error("debugger reset lost");
	AST_BREAK_RESET_BLOCK: assert property ( // R9
		MAIN_IN_BREAK && !DBG_RESET_REQ |=> !ALL_CORE_RST)
		else $error("reset generated during break");
	AST_PERI_STOP: assert property ( // R10
		PERI_BRK_EN && MAIN_IN_BREAK |=> PERI_STOP)
		else $error("peripherals not stopped in break");
	AST_PERI_RUN: assert property ( // R10
		!(PERI_BRK_EN && MAIN_IN_BREAK) |=> !PERI_STOP)
		else $error("peripherals stopped outside break");
	AST_DENY: assert property ( // R12
		(DBG_EXEC_REQ || DBG_MEM_REQ) && !main_ok |=> ACC_DENIED && !EXEC_GRANT && !MEM_GRANT)
		else $error("access leaked before authentication");
endmodule : dbg_auth_ctrl

// File: verif/dbg_probe_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// debug probe model
// ----------------------------------------
module dbg_probe_model (
	// clock
	input wire logic clk,
	// connection
	output logic pin,
	output logic auth_req,
	output logic target,
	// challenge and response streams
	output logic chal_rdy,
	input wire logic chal_stb,
	input wire logic chal_bit,
	output logic resp_stb,
	output logic resp_bit,
	output logic [127:0] chal_got
);
	initial begin
		pin = 1'b0;
		auth_req = 1'b0;
		target = 1'b0;
		chal_rdy = 1'b0;
		resp_stb = 1'b0;
		resp_bit = 1'b0;
		chal_got = 128'h0;
	end
	always @(posedge clk) begin
		if (chal_stb === 1'b1) begin
			chal_got <= {chal_got[126:0], chal_bit};
		end
	end
	task connect(input logic tgt, input logic req);
		@(posedge clk);
		#1;
		target = tgt;
		auth_req = req;
		pin = 1'b1;
	endtask : connect
	task drop;
		pin = 1'b0;
	endtask : drop
	task take_chal;
		chal_rdy = 1'b1;
		repeat (128) @(posedge clk);
		#1;
		chal_rdy = 1'b0;
	endtask : take_chal
	task send_resp(input logic [127:0] word);
		int i;
		for (i = 127; i >= 0; i--) begin
			resp_stb = 1'b1;
			resp_bit = word[i];
			@(posedge clk);
			#1;
		end
		resp_stb = 1'b0;
		// idle line shows the inverse so a late sample cannot match by luck
		resp_bit = ~resp_bit;
	endtask : send_resp
endmodule : dbg_probe_model

// File: verif/main_core_debug_auth_control_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// testbench
// ----------------------------------------
module main_core_debug_auth_control_test;
	import dbg_auth_pkg::*;
	logic sys_clk, rst_n, pin, areq, tgt, conn, auth_ok, auth_err, chal_rdy, chal_stb, chal_bit;
	logic resp_stb, resp_bit, sec_chal_req, sec_chal_target, sec_chal_valid, sec_resp_valid;
	logic sec_verdict_valid, sec_verdict_pass, exec_req, mem_req, flash_acc, optb_acc, patch;
	logic exec_grant, mem_grant, acc_denied, sec_halt, dbg_rst, sec_rst, brk, peri_en;
	logic all_core_rst, peri_stop;
	logic [NUM_TARGETS-1:0] granted;
	logic [CR_WIDTH-1:0] sec_chal_data, sec_resp_data;
	int mismatches, compares;
	dbg_probe_model probe (.clk(sys_clk), .pin(pin), .auth_req(areq), .target(tgt),
		.chal_rdy(chal_rdy), .chal_stb(chal_stb), .chal_bit(chal_bit),
		.resp_stb(resp_stb), .resp_bit(resp_bit), .chal_got());
	dbg_auth_ctrl DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .DBG_CONNECT_PIN(pin),
		.DBG_AUTH_REQUIRED(areq), .DBG_TARGET(tgt), .DBG_CONNECTED(conn), .AUTH_OK(auth_ok),
		.AUTH_ERR(auth_err), .AUTH_GRANTED(granted), .CHAL_RDY(chal_rdy), .CHAL_STB(chal_stb),
		.CHAL_BIT(chal_bit), .RESP_STB(resp_stb), .RESP_BIT(resp_bit),
		.SEC_CHAL_REQ(sec_chal_req), .SEC_CHAL_TARGET(sec_chal_target),
		.SEC_CHAL_VALID(sec_chal_valid), .SEC_CHAL_DATA(sec_chal_data),
		.SEC_RESP_VALID(sec_resp_valid), .SEC_RESP_DATA(sec_resp_data),
		.SEC_VERDICT_VALID(sec_verdict_valid), .SEC_VERDICT_PASS(sec_verdict_pass),
		.DBG_EXEC_REQ(exec_req), .DBG_MEM_REQ(mem_req), .DBG_FLASH_ACC(flash_acc),
		.DBG_OPTB_ACC(optb_acc), .DBG_SWBRK_PATCH(patch), .EXEC_GRANT(exec_grant),
		.MEM_GRANT(mem_grant), .ACC_DENIED(acc_denied), .SEC_HALT(sec_halt),
		.DBG_RESET_REQ(dbg_rst), .SEC_RESET_REQ(sec_rst), .MAIN_IN_BREAK(brk),
		.PERI_BRK_EN(peri_en), .ALL_CORE_RST(all_core_rst), .PERI_STOP(peri_stop));
	always #20 sys_clk = ~sys_clk;
	task tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task chk(input string name, input logic [127:0] exp, input logic [127:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task drop_link;
		probe.drop;
		repeat (5) tick;
		chk("conn_drop", 1'b0, conn);
		chk("grant_drop", 2'h0, granted);
	endtask : drop_link
	task run_auth(input logic t, input logic ok, input logic [127:0] ch, input logic [127:0] rs);
		int i;
		probe.connect(t, 1'b1);
		for (i = 0; i < 8 && sec_chal_req !== 1'b1; i++) tick;
		chk("chal_req", 1'b1, sec_chal_req);
		chk("chal_tgt", t, sec_chal_target);
		sec_chal_valid = 1'b1;
		sec_chal_data = ch;
		tick;
		sec_chal_valid = 1'b0;
		sec_chal_data = ~ch;
		probe.take_chal;
		repeat (2) tick;
		chk("chal_bits", ch, probe.chal_got);
		chk("early_conn", 1'b0, conn);
		probe.send_resp(rs);
		chk("resp_vld", 1'b1, sec_resp_valid);
		chk("resp_data", rs, sec_resp_data);
		sec_verdict_valid = 1'b1;
		sec_verdict_pass = ok;
		tick;
		sec_verdict_valid = 1'b0;
		chk("auth_ok", ok, auth_ok);
		chk("auth_err", !ok, auth_err);
		chk("connected", ok, conn);
		chk("granted", ok ? 2'(2'h1 << t) : 2'h0, granted);
		$display("test auth target %0d pass %0d done", t, ok);
	endtask : run_auth
	task t_access(input logic ok);
		int i;
		exec_req = 1'b1;
		mem_req = 1'b1;
		tick;
		chk("exec_grant", ok, exec_grant);
		chk("mem_grant", ok, mem_grant);
		chk("acc_denied", !ok, acc_denied);
		exec_req = 1'b0;
		mem_req = 1'b0;
		for (i = 0; i < 3; i++) begin
			{patch, optb_acc, flash_acc} = 3'(3'h1 << i);
			tick;
			chk("sec_halt", ok, sec_halt);
			chk("mem_flash", ok && i < 2, mem_grant);
		end
		{patch, optb_acc, flash_acc} = 3'h0;
		tick;
		chk("halt_off", 1'b0, sec_halt);
		$display("test access %0d done", ok);
	endtask : t_access
	task t_core_reset;
		dbg_rst = 1'b1;
		brk = 1'b1;
		tick;
		chk("rst_dbg", 1'b1, all_core_rst);
		dbg_rst = 1'b0;
		sec_rst = 1'b1;
		tick;
		chk("rst_brk", 1'b0, all_core_rst);
		brk = 1'b0;
		tick;
		chk("rst_sec", 1'b1, all_core_rst);
		sec_rst = 1'b0;
		brk = 1'b1;
		peri_en = 1'b1;
		tick;
		chk("peri_stop", 1'b1, peri_stop);
		peri_en = 1'b0;
		tick;
		chk("peri_run", 1'b0, peri_stop);
		brk = 1'b0;
		$display("test core reset done");
	endtask : t_core_reset
	initial begin
		#(40 * 10000);
		mismatches++;
		report_and_stop;
	end
	initial begin
		{sys_clk, rst_n, sec_chal_valid, sec_verdict_valid, sec_verdict_pass} = 5'h0;
		{exec_req, mem_req, flash_acc, optb_acc, patch, dbg_rst, sec_rst, brk, peri_en} = 9'h0;
		sec_chal_data = CR_ZERO;
		repeat (4) tick;
		rst_n = 1'b1;
		tick;
		chk("rst_out", 5'h0, {conn, granted, all_core_rst, sec_halt});
		t_access(1'b0);
		run_auth(1'b0, 1'b1, 128'h000102030405060708090A0B0C0D0E0F,
			128'h0F1F2F3F4F5F6F7F8F9FAFBFCFDFEFFF);
		t_access(1'b1);
		drop_link;
		run_auth(1'b1, 1'b0, 128'hF0E0D0C0B0A090807060504030201000, 128'h8000000000000001);
		t_access(1'b0);
		drop_link;
		run_auth(1'b1, 1'b1, 128'h5A5A0000FFFF1234C3C3000000000001, 128'h1);
		drop_link;
		probe.connect(1'b0, 1'b0);
		repeat (5) tick;
		chk("noauth_grant", 2'h1, granted);
		chk("noauth_conn", 1'b1, conn);
		drop_link;
		t_core_reset;
		report_and_stop;
	end
endmodule : main_core_debug_auth_control_test
